// ===== mls_pkg.sv
package mls_pkg;

  // Clock and update interval
  localparam int CLK_PERIOD_NS       = 4;
  localparam int DUTY_INTERVAL_NS    = 2_700_000;
  localparam int DUTY_INTERVAL_CYC   = DUTY_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int LOCK_UNIT_CYC       = 250_000_000;
  localparam int PWM_TIMEOUT_NS      = 1_000_000;
  localparam int PWM_TIMEOUT_CYC     = PWM_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int LOCK_SOFT_MULT      = 5;

  // Register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_START_I = 8'h04;
  localparam logic [7:0] OFS_START_F = 8'h08;
  localparam logic [7:0] OFS_VLOW    = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_LEAD    = 8'h14;

  // Control field positions
  localparam int POS_LEAD_CODE  = 0;
  localparam int POS_LEAD_SRC   = 5;
  localparam int POS_SOFT_LOCK  = 6;
  localparam int POS_DUTY_SLEW  = 7;
  localparam int POS_SRC_SEL    = 10;
  localparam int POS_SINK_SEL   = 13;
  localparam int POS_STEP_LIM   = 16;
  localparam int POS_IN_ANALOG  = 19;
  localparam int POS_IN_NEG     = 20;

  // Reset values
  localparam logic [2:0] RST_DUTY_SLEW = 3'h2;
  localparam logic [9:0] RST_START_I   = 10'h080;
  localparam logic [15:0] RST_START_F  = 16'h0014;
  localparam logic [9:0] RST_VLOW      = 10'h040;

  // Numeric limits
  localparam logic [9:0]  FULL_SCALE   = 10'h200;
  localparam logic [12:0] FULL_FINE    = 13'h1000;
  localparam logic [9:0]  LEAD_SAT     = 10'h1f0;
  localparam logic [4:0]  LEAD_FIXED0  = 5'h1c;
  localparam logic [8:0]  OPT_MAX      = 9'h0ff;
  localparam logic [15:0] RPM_PER_CMD  = 16'h0014;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_SOFT = 3'b010,
    ST_RUN  = 3'b100
  } mls_state_t;

  typedef struct packed {
    logic       inNegative;
    logic       inAnalog;
    logic [2:0] stepLimit;
    logic [2:0] sinkSel;
    logic [2:0] srcSel;
    logic [2:0] dutySlew;
    logic       softLockSel;
    logic       leadSourceSelect;
    logic [4:0] leadTableCode;
  } mls_cfg_t;

  typedef struct packed {
    logic [2:0] sourceCode;
    logic [2:0] sinkCode;
  } mls_gate_t;

endpackage : mls_pkg

// ===== mls_motor_ctrl.sv
`timescale 1ns/1ps
module mls_motor_ctrl #(
  parameter int INTERVAL_CYC = mls_pkg::DUTY_INTERVAL_CYC,
  parameter int LOCK_UNIT    = mls_pkg::LOCK_UNIT_CYC,
  parameter int PWM_TIMEOUT  = mls_pkg::PWM_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Register port
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [31:0]      regRdata,
  // Speed command
  input  wire logic             speedCommandPin,
  input  wire logic [9:0]       adcCode,
  // Motor feedback
  input  wire logic [15:0]      motorRpm,
  input  wire logic [15:0]      motorFreqHz,
  input  wire logic [9:0]       motorCurrent,
  input  wire logic             hallEdge,
  input  wire logic             currentZeroCross,
  // Drive outputs
  output logic      [9:0]       dutyOut,
  output logic      [9:0]       leadAngle,
  output logic      [15:0]      freqCommand,
  output logic      [15:0]      rpmTarget,
  output mls_pkg::mls_gate_t    gateDrive,
  output logic                  lockFault,
  output logic                  serialClk
);
  import mls_pkg::*;

  if (INTERVAL_CYC < 2 || LOCK_UNIT < 2 || PWM_TIMEOUT < 2) begin : g_chk
    $error("Timing counts must be at least two cycles");
  end

  logic        rstSync1_reg, rstN;
  mls_cfg_t    cfgReg;
  logic [9:0]  startIReg;
  logic [15:0] startFReg;
  logic [9:0]  vLowReg;
  mls_state_t  stateReg;
  logic [12:0] dutyFineReg;
  logic [8:0]  optAngleReg;
  logic        hallSeenReg;
  logic [31:0] hallIdleReg;
  logic [31:0] tickCntReg;
  logic        tick;
  logic [9:0]  cmdReg;
  logic        pinPrevReg;
  logic [19:0] perCntReg, highCntReg, perLatReg;
  logic [29:0] numReg;
  logic [9:0]  quotReg;
  logic [3:0]  divBitReg;
  logic        divBusyReg;
  logic [9:0]  pwmCmdReg;

  // Reset release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1_reg <= 1'b0;
      rstN         <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN         <= rstSync1_reg;
    end
  end

  // Register writes
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cfgReg          <= '0;
      cfgReg.dutySlew <= RST_DUTY_SLEW;
      startIReg       <= RST_START_I;
      startFReg       <= RST_START_F;
      vLowReg         <= RST_VLOW;
    end else if (regWr) begin
      unique case (regAddr)
        OFS_CTRL:    cfgReg    <= mls_cfg_t'(regWdata[20:0]);
        OFS_START_I: startIReg <= regWdata[9:0];
        OFS_START_F: startFReg <= regWdata[15:0];
        OFS_VLOW:    vLowReg   <= regWdata[9:0];
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_CTRL:    regRdata <= {11'h000, cfgReg};
        OFS_START_I: regRdata <= {22'h000000, startIReg};
        OFS_START_F: regRdata <= {16'h0000, startFReg};
        OFS_VLOW:    regRdata <= {22'h000000, vLowReg};
        OFS_STATUS:  regRdata <= {lockFault, 12'h000, stateReg,
                                  6'h00, cmdReg};
        OFS_LEAD:    regRdata <= {7'h00, optAngleReg, 6'h00, leadAngle};
        default:     regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // Update interval tick
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      tickCntReg <= '0;
    end else if (tickCntReg == 32'(INTERVAL_CYC - 1)) begin
      tickCntReg <= '0;
    end else begin
      tickCntReg <= tickCntReg + 32'h1;
    end
  end
  assign tick = (tickCntReg == 32'(INTERVAL_CYC - 1));

  // PWM duty measurement, inverted for negative logic
  logic pinLevel;
  assign pinLevel = speedCommandPin ^ cfgReg.inNegative;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pinPrevReg <= 1'b0;
      perCntReg  <= '0;
      highCntReg <= '0;
      perLatReg  <= '0;
      numReg     <= '0;
      quotReg    <= '0;
      divBitReg  <= '0;
      divBusyReg <= 1'b0;
      pwmCmdReg  <= '0;
    end else begin
      pinPrevReg <= pinLevel;
      if (pinLevel && !pinPrevReg) begin
        perCntReg  <= 20'h1;
        highCntReg <= 20'h1;
        perLatReg  <= perCntReg;
        numReg     <= {highCntReg[19:0], 10'h000} >> 1;
        quotReg    <= '0;
        divBitReg  <= 4'h9;
        divBusyReg <= (perCntReg != '0);
      end else begin
        if (perCntReg != 20'(PWM_TIMEOUT)) begin
          perCntReg <= perCntReg + 20'h1;
        end else begin
          pwmCmdReg <= pinLevel ? FULL_SCALE : 10'h000;
        end
        if (pinLevel) begin
          highCntReg <= highCntReg + 20'h1;
        end
        if (divBusyReg) begin
          if (numReg >= ({10'h000, perLatReg} << divBitReg)) begin
            numReg  <= numReg - ({10'h000, perLatReg} << divBitReg);
            quotReg <= quotReg | (10'h001 << divBitReg);
          end
          if (divBitReg == 4'h0) begin
            divBusyReg <= 1'b0;
          end else begin
            divBitReg <= divBitReg - 4'h1;
          end
        end else if (perCntReg != 20'(PWM_TIMEOUT)) begin
          pwmCmdReg <= (quotReg > FULL_SCALE) ? FULL_SCALE : quotReg;
        end
      end
    end
  end

  // Analog window of 512 codes above the low threshold
  logic [10:0] anaDiff;
  logic [9:0]  anaCmd;
  always_comb begin
    anaDiff = {1'b0, adcCode} - {1'b0, vLowReg};
    if (adcCode < vLowReg) begin
      anaCmd = 10'h000;
    end else if (anaDiff >= {1'b0, FULL_SCALE}) begin
      anaCmd = FULL_SCALE;
    end else begin
      anaCmd = anaDiff[9:0];
    end
  end

  // Speed command selection
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cmdReg <= '0;
    end else if (cfgReg.inAnalog) begin
      cmdReg <= cfgReg.inNegative ? FULL_SCALE - anaCmd : anaCmd;
    end else begin
      cmdReg <= pwmCmdReg;
    end
  end

  // Serial clock shares the speed pin
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      serialClk <= 1'b0;
    end else begin
      serialClk <= speedCommandPin;
    end
  end

  // Hall activity watch
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      hallIdleReg <= '0;
    end else if (hallEdge) begin
      hallIdleReg <= '0;
    end else if (hallIdleReg != 32'hffffffff) begin
      hallIdleReg <= hallIdleReg + 32'h1;
    end
  end

  // Duty slew step in eighths of a 512th
  function automatic logic [6:0] slewStep(input logic [2:0] code);
    unique case (code)
      3'h0: slewStep = 7'h40;
      3'h1: slewStep = 7'h02;
      3'h2: slewStep = 7'h03;
      3'h3: slewStep = 7'h04;
      3'h4: slewStep = 7'h06;
      3'h5: slewStep = 7'h0a;
      3'h6: slewStep = 7'h14;
      3'h7: slewStep = 7'h38;
    endcase
  endfunction : slewStep

  logic [12:0] stepFine, targetFine, upFine;
  logic [31:0] lockLimit;
  assign stepFine   = {6'h00, slewStep(cfgReg.dutySlew)};
  assign targetFine = {cmdReg, 3'h0};
  assign upFine     = (dutyFineReg + stepFine > FULL_FINE) ? FULL_FINE :
                      dutyFineReg + stepFine;
  assign lockLimit  = cfgReg.softLockSel ?
                      32'(LOCK_UNIT * LOCK_SOFT_MULT) : 32'(LOCK_UNIT);

  // Start sequence and duty control
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      stateReg    <= ST_STOP;
      dutyFineReg <= '0;
      freqCommand <= '0;
      lockFault   <= 1'b0;
    end else begin
      unique case (stateReg)
        ST_STOP: begin
          dutyFineReg <= '0;
          freqCommand <= '0;
          // Lock fault holds until the command is withdrawn
          if (cmdReg == '0) begin
            lockFault <= 1'b0;
          end else if (!lockFault) begin
            stateReg    <= ST_SOFT;
            freqCommand <= 16'h0001;
          end
        end
        ST_SOFT: begin
          if (cmdReg == '0) begin
            stateReg <= ST_STOP;
          end else if (hallIdleReg >= lockLimit) begin
            stateReg  <= ST_STOP;
            lockFault <= 1'b1;
          end else if (freqCommand >= startFReg) begin
            stateReg <= ST_RUN;
          end else if (tick) begin
            freqCommand <= freqCommand + 16'h1;
            if (motorCurrent < startIReg) begin
              dutyFineReg <= upFine;
            end
          end
        end
        ST_RUN: begin
          if (cmdReg == '0 && dutyFineReg == '0) begin
            stateReg <= ST_STOP;
          end else if (tick) begin
            if (targetFine > dutyFineReg) begin
              dutyFineReg <= (targetFine - dutyFineReg > stepFine) ?
                             upFine : targetFine;
            end else if (dutyFineReg - targetFine > stepFine) begin
              dutyFineReg <= dutyFineReg - stepFine;
            end else begin
              dutyFineReg <= targetFine;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      dutyOut <= '0;
    end else begin
      dutyOut <= dutyFineReg[12:3];
    end
  end

  // Speed reduction step limit
  logic [15:0] stepRpm, wantRpm;
  logic [25:0] wantWide;
  always_comb begin
    unique case (cfgReg.stepLimit)
      3'h0: stepRpm = 16'hffff;
      3'h1: stepRpm = 16'd512;
      3'h2: stepRpm = 16'd2200;
      3'h3: stepRpm = 16'd3800;
      3'h4: stepRpm = 16'd5400;
      3'h5: stepRpm = 16'd7000;
      3'h6: stepRpm = 16'd8600;
      3'h7: stepRpm = 16'd10240;
    endcase
    wantWide = {16'h0000, cmdReg} * {10'h000, RPM_PER_CMD};
    wantRpm  = wantWide[15:0];
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rpmTarget <= '0;
    end else if (tick) begin
      if (wantRpm < rpmTarget && rpmTarget - wantRpm > stepRpm) begin
        rpmTarget <= rpmTarget - stepRpm;
      end else begin
        rpmTarget <= wantRpm;
      end
    end
  end

  // Gate drive strength codes
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      gateDrive <= '0;
    end else begin
      gateDrive.sourceCode <= cfgReg.srcSel;
      gateDrive.sinkCode   <= cfgReg.sinkSel;
    end
  end

  // Lead optimiser from Hall and current zero crossings
  logic hallActive, optRun;
  assign hallActive = (hallIdleReg < 32'(LOCK_UNIT));
  assign optRun     = !cfgReg.leadSourceSelect && hallActive &&
                      motorFreqHz >= startFReg;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      optAngleReg <= '0;
      hallSeenReg <= 1'b0;
    end else if (!optRun) begin
      optAngleReg <= '0;
      hallSeenReg <= 1'b0;
    end else begin
      if (currentZeroCross) begin
        hallSeenReg <= hallEdge;
        if (hallSeenReg && optAngleReg < OPT_MAX) begin
          optAngleReg <= optAngleReg + 9'h1;
        end else if (!hallSeenReg && optAngleReg != '0) begin
          optAngleReg <= optAngleReg - 9'h1;
        end
      end else if (hallEdge) begin
        hallSeenReg <= 1'b1;
      end
    end
  end

  // Lead table, units of 1.875/16 degree
  logic [20:0] propWide;
  logic [9:0]  tableLead;
  always_comb begin
    propWide = {5'h00, motorRpm} * {16'h0000, cfgReg.leadTableCode};
    if (!hallActive) begin
      tableLead = 10'h000;
    end else if (cfgReg.leadTableCode >= LEAD_FIXED0) begin
      tableLead = {1'b0, {1'b0, cfgReg.leadTableCode[1:0]} + 3'h1,
                   6'h00};
    end else if (propWide[20:8] > {3'h0, LEAD_SAT}) begin
      tableLead = LEAD_SAT;
    end else begin
      tableLead = propWide[17:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      leadAngle <= '0;
    end else begin
      leadAngle <= tableLead + {1'b0, optAngleReg};
    end
  end

  // Checks
  property p_leadFixed;
    @(posedge sys_clk) disable iff (!rstN)
      cfgReg.leadTableCode == 5'h1c && optAngleReg == '0 && hallActive
      |=> leadAngle == 10'h040;
  endproperty
  a_leadFixed: assert property (p_leadFixed)
    else $error("fixed lead code gave wrong angle");

  property p_leadSat;
    @(posedge sys_clk) disable iff (!rstN)
      cfgReg.leadTableCode < LEAD_FIXED0 && optAngleReg == '0
      |=> leadAngle <= LEAD_SAT;
  endproperty
  a_leadSat: assert property (p_leadSat)
    else $error("lead angle above saturation");

  property p_optOff;
    @(posedge sys_clk) disable iff (!rstN)
      cfgReg.leadSourceSelect |=> optAngleReg == '0;
  endproperty
  a_optOff: assert property (p_optOff)
    else $error("optimiser not held at zero");

  property p_optSlow;
    @(posedge sys_clk) disable iff (!rstN)
      motorFreqHz < startFReg |=> optAngleReg == '0;
  endproperty
  a_optSlow: assert property (p_optSlow)
    else $error("optimiser active below startup frequency");

  property p_softEntry;
    @(posedge sys_clk) disable iff (!rstN)
      stateReg == ST_STOP && cmdReg != '0 && !lockFault
      |=> stateReg == ST_SOFT && freqCommand == 16'h0001;
  endproperty
  a_softEntry: assert property (p_softEntry)
    else $error("start from stop skipped soft start");

  property p_dutyBound;
    @(posedge sys_clk) disable iff (!rstN)
      dutyOut <= FULL_SCALE && cmdReg <= FULL_SCALE;
  endproperty
  a_dutyBound: assert property (p_dutyBound)
    else $error("duty or command beyond full scale");

  property p_slewHold;
    @(posedge sys_clk) disable iff (!rstN)
      stateReg == ST_RUN && !tick && !(cmdReg == '0 && dutyFineReg == '0)
      |=> $stable(dutyFineReg);
  endproperty
  a_slewHold: assert property (p_slewHold)
    else $error("duty changed between update intervals");

  property p_slewStep;
    @(posedge sys_clk) disable iff (!rstN)
      stateReg == ST_RUN && tick |=>
        (dutyFineReg >= $past(dutyFineReg) ?
         dutyFineReg - $past(dutyFineReg) :
         $past(dutyFineReg) - dutyFineReg) <= $past(stepFine);
  endproperty
  a_slewStep: assert property (p_slewStep)
    else $error("duty step exceeds slew limit");

  property p_handoff;
    @(posedge sys_clk) disable iff (!rstN)
      stateReg == ST_SOFT && cmdReg != '0 && hallIdleReg < lockLimit &&
      freqCommand >= startFReg |=> stateReg == ST_RUN;
  endproperty
  a_handoff: assert property (p_handoff)
    else $error("soft start did not hand over");

  property p_stopZero;
    @(posedge sys_clk) disable iff (!rstN)
      stateReg == ST_STOP ##1 stateReg == ST_SOFT |-> dutyFineReg == '0;
  endproperty
  a_stopZero: assert property (p_stopZero)
    else $error("soft start did not begin at zero duty");

  c_toRun: cover property (@(posedge sys_clk) disable iff (!rstN)
    stateReg == ST_SOFT ##1 stateReg == ST_RUN);
  c_lock: cover property (@(posedge sys_clk) disable iff (!rstN)
    $rose(lockFault));
  c_stepCap: cover property (@(posedge sys_clk) disable iff (!rstN)
    tick && wantRpm < rpmTarget && rpmTarget - wantRpm > stepRpm);

endmodule : mls_motor_ctrl

// ===== mls_host_model.sv
`timescale 1ns/1ps
module mls_host_model (
  // Clock
  input  wire logic        sys_clk,
  // Stimulus control
  input  wire logic        pwmEn,
  input  wire logic [11:0] pwmHigh,
  input  wire logic        hallOn,
  input  wire logic [9:0]  dutyOut,
  // Far side signals
  output logic             speedCommandPin = 1'b0,
  output logic             hallEdge = 1'b0,
  output logic             currentZeroCross = 1'b0,
  output logic [9:0]       motorCurrent = 10'h000
);
  logic [11:0] pwmCnt  = 12'h000;
  logic [5:0]  hallCnt = 6'h00;
  // Speed command at 100 kHz, 2500 cycles a period
  always @(posedge sys_clk) begin
    pwmCnt <= (pwmCnt == 12'h9c3) ? 12'h000 : pwmCnt + 12'h001;
    speedCommandPin <= pwmEn && (pwmCnt < pwmHigh);
  end
  // Hall edge every 50 cycles, current zero cross 5 later
  always @(posedge sys_clk) begin
    hallCnt <= (hallCnt == 6'h31) ? 6'h00 : hallCnt + 6'h01;
    hallEdge <= hallOn && (hallCnt == 6'h00);
    currentZeroCross <= hallOn && (hallCnt == 6'h05);
    motorCurrent <= dutyOut;
  end
endmodule : mls_host_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import mls_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        rdSeen = 1'b0;
  logic [9:0]  adcCode = 10'h000;
  logic [15:0] motorRpm = 16'h0;
  logic [15:0] motorFreqHz = 16'h0;
  logic        pwmEn = 1'b0;
  logic [11:0] pwmHigh = 12'h271;
  logic        hallOn = 1'b0;
  logic        pin, hallEdge, curZc, serialClk, lockFault, p;
  logic [9:0]  motorCurrent, dutyOut, leadAngle, d0;
  logic [15:0] freqCommand, rpmTarget;
  logic [31:0] regRdata;
  logic [63:0] ent;
  logic [63:0] expQ[$];
  mls_gate_t   gateDrive;
  mls_cfg_t    cfg;
  int          bad_count = 0;
  int          n_tests = 0;
  int          i, v, e, c;

  mls_motor_ctrl #(.INTERVAL_CYC(20), .LOCK_UNIT(200), .PWM_TIMEOUT(3000))
    i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .speedCommandPin(pin), .adcCode(adcCode), .motorRpm(motorRpm),
    .motorFreqHz(motorFreqHz), .motorCurrent(motorCurrent),
    .hallEdge(hallEdge), .currentZeroCross(curZc), .dutyOut(dutyOut),
    .leadAngle(leadAngle), .freqCommand(freqCommand),
    .rpmTarget(rpmTarget), .gateDrive(gateDrive), .lockFault(lockFault),
    .serialClk(serialClk));
  mls_host_model i_host (.sys_clk(sys_clk), .pwmEn(pwmEn),
    .pwmHigh(pwmHigh), .hallOn(hallOn), .dutyOut(dutyOut),
    .speedCommandPin(pin), .hallEdge(hallEdge), .currentZeroCross(curZc),
    .motorCurrent(motorCurrent));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    expQ.push_back({m, x});
    @(posedge sys_clk);
    regRd   <= 1'b0;
  endtask : rd
  task automatic wcfg();
    wr(OFS_CTRL, {11'h0, cfg});
  endtask : wcfg
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Read data stand in the cycle after the strobe
  always @(posedge sys_clk) rdSeen <= regRd;
  always @(negedge sys_clk) begin
    if (rdSeen) begin
      ent = expQ.pop_front();
      check(regRdata & ent[63:32], ent[31:0]);
    end
  end
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    #400000;
    bad_count++;
    conclude();
  end

  initial begin
    i = $urandom(32'h43b5);
    cyc(3);
    reset_n <= 1'b1;
    cyc(3);
    rd(OFS_CTRL, 32'h100, 32'hffffffff);
    rd(OFS_START_I, 32'h80, 32'hffffffff);
    rd(OFS_START_F, 32'h14, 32'hffffffff);
    rd(OFS_VLOW, 32'h40, 32'hffffffff);
    rd(8'h20, 32'h0, 32'hffffffff);
    cfg = '0;
    cfg.inAnalog = 1'b1;
    for (i = 0; i < 8; i++) begin
      cfg.srcSel  = 3'(i);
      cfg.sinkSel = 3'(7 - i);
      wcfg();
      cyc(3);
      @(negedge sys_clk);
      check({26'h0, gateDrive}, 32'(i * 8 + 7 - i));
    end
    @(posedge sys_clk);
    hallOn <= 1'b1;
    for (i = 0; i < 12; i++) begin
      c = (i < 4) ? 28 + i : $urandom_range(27);
      v = $urandom_range(8000);
      @(posedge sys_clk);
      motorRpm <= 16'(v);
      cfg.leadTableCode    = 5'(c);
      cfg.leadSourceSelect = i[0];
      wcfg();
      cyc(4);
      e = (c > 27) ? (c - 27) * 64 : v * c / 256;
      e = (e > 496) ? 496 : e;
      @(negedge sys_clk);
      check({22'h0, leadAngle}, 32'(e));
    end
    cfg.leadTableCode    = 5'h00;
    cfg.leadSourceSelect = 1'b0;
    @(posedge sys_clk);
    motorFreqHz <= 16'h0064;
    wcfg();
    cyc(500);
    @(negedge sys_clk);
    check({31'h0, leadAngle >= 8 && leadAngle <= 11}, 32'h1);
    cfg.leadSourceSelect = 1'b1;
    wcfg();
    cyc(3);
    @(negedge sys_clk);
    check({22'h0, leadAngle}, 32'h0);
    @(posedge sys_clk);
    hallOn <= 1'b0;
    cfg.leadTableCode = 5'h1f;
    wcfg();
    cyc(300);
    @(negedge sys_clk);
    check({22'h0, leadAngle}, 32'h0);
    for (i = 0; i < 8; i++) begin
      cfg.inNegative = i[0];
      wcfg();
      v = $urandom_range(1023);
      adcCode <= 10'(v);
      cyc(3);
      e = (v < 64) ? 0 : (v - 64 > 512) ? 512 : v - 64;
      e = i[0] ? 512 - e : e;
      rd(OFS_STATUS, 32'(e), 32'h3ff);
    end
    cfg.inAnalog = 1'b0;
    pwmEn <= 1'b1;
    for (i = 0; i < 2; i++) begin
      cfg.inNegative = i[0];
      wcfg();
      cyc(7500);
      rd(OFS_STATUS, i[0] ? 32'h180 : 32'h80, 32'h3ff);
      @(negedge sys_clk);
      p = pin;
      @(negedge sys_clk);
      check({31'h0, serialClk}, {31'h0, p});
    end
    @(posedge sys_clk);
    pwmEn <= 1'b0;
    cfg = '0;
    cfg.inAnalog = 1'b1;
    cfg.dutySlew = 3'h7;
    wcfg();
    adcCode <= 10'h000;
    wr(OFS_START_F, 32'h3);
    hallOn <= 1'b1;
    cyc(2000);
    rd(OFS_STATUS, 32'h10000, 32'h70000);
    adcCode <= 10'h1d0;
    cyc(4);
    @(negedge sys_clk);
    check({31'h0, freqCommand <= 2 && freqCommand >= 1}, 32'h1);
    check({31'h0, dutyOut <= 7}, 32'h1);
    rd(OFS_STATUS, 32'h20000, 32'h70000);
    cyc(120);
    rd(OFS_STATUS, 32'h40000, 32'h70000);
    @(negedge sys_clk);
    d0 = dutyOut;
    cyc(200);
    @(negedge sys_clk);
    v = int'(dutyOut) - int'(d0);
    check({31'h0, v >= 63 && v <= 77}, 32'h1);
    cfg.stepLimit = 3'h1;
    wcfg();
    adcCode <= 10'h0a4;
    cyc(30);
    @(negedge sys_clk);
    v = 8000 - int'(rpmTarget);
    check({31'h0, v % 512 == 0 && v > 0 && v <= 1024}, 32'h1);
    @(posedge sys_clk);
    adcCode <= 10'h000;
    cyc(600);
    cfg.softLockSel = 1'b1;
    wcfg();
    wr(OFS_START_F, 32'h3e8);
    hallOn  <= 1'b0;
    adcCode <= 10'h1d0;
    cyc(600);
    @(negedge sys_clk);
    check({31'h0, lockFault}, 32'h0);
    cyc(600);
    @(negedge sys_clk);
    check({31'h0, lockFault}, 32'h1);
    rd(OFS_STATUS, 32'h80010000, 32'h80070000);
    cyc(2);
    conclude();
  end
endmodule : testbench
